// ---- src/lps_pkg.sv ----
// Purpose: shared constants and types of the lcd pointer and mode setup
// Assumes: 8-bit host bytes, 16-bit display and character memory address
// Notes: command codes, field positions, reset values and fsm codes

package lps_pkg;

  // ---------------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------------
  localparam logic [7:0] LPS_CMD_CURSOR = 8'h21;
  localparam logic [7:0] LPS_CMD_OFFSET = 8'h22;
  localparam logic [7:0] LPS_CMD_ADDR_PTR = 8'h24;
  localparam logic [7:0] LPS_CMD_TEXT_BASE = 8'h40;
  localparam logic [7:0] LPS_CMD_TEXT_WIDTH = 8'h41;
  localparam logic [7:0] LPS_CMD_GRAPHIC_BASE = 8'h42;
  localparam logic [7:0] LPS_CMD_GRAPHIC_WIDTH = 8'h43;
  localparam logic [3:0] LPS_CMD_MODE_SET_HI = 4'h8;

  // ---------------------------------------------------------------------
  // mode set fields
  // ---------------------------------------------------------------------
  localparam int LPS_MODE_EXT_BIT = 3;
  localparam logic [2:0] LPS_MODE_OR = 3'h0;
  localparam logic [2:0] LPS_MODE_XOR = 3'h1;
  localparam logic [2:0] LPS_MODE_AND = 3'h3;
  localparam logic [2:0] LPS_MODE_ATTR = 3'h4;

  // ---------------------------------------------------------------------
  // field widths and positions
  // ---------------------------------------------------------------------
  localparam int LPS_ADDR_W = 16;
  localparam int LPS_CUR_X_W = 7;
  localparam int LPS_CUR_Y_W = 5;
  localparam int LPS_CUR_HALF_BIT = 4;
  localparam int LPS_OFFSET_W = 5;
  localparam int LPS_COLS_W = 7;
  localparam logic [7:0] LPS_ROM_LAST_CODE = 8'h7f;

  // ---------------------------------------------------------------------
  // attribute low nibble
  // ---------------------------------------------------------------------
  localparam int LPS_ATTR_BLINK_BIT = 3;
  localparam logic [2:0] LPS_ATTR_NORMAL = 3'h0;
  localparam logic [2:0] LPS_ATTR_REVERSE = 3'h5;
  localparam logic [2:0] LPS_ATTR_INHIBIT = 3'h3;
  localparam logic [2:0] LPS_ATTR_BOLD = 3'h7;

  // ---------------------------------------------------------------------
  // reset values and fixed counts
  // ---------------------------------------------------------------------
  localparam logic [15:0] LPS_RST_ADDR = 16'h0000;
  localparam logic [7:0] LPS_RST_BYTE = 8'h00;
  localparam logic [2:0] LPS_RST_MODE = 3'h0;
  localparam logic [6:0] LPS_COLS_BOTH_HIGH = 7'h20;
  localparam logic [6:0] LPS_RST_COLS = 7'h20;

  // ---------------------------------------------------------------------
  // fetch address sequencer
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    LPS_F_IDLE = 2'b01,
    LPS_F_CALC = 2'b10
  } lps_fetch_t;

endpackage

// ---- src/lps_sync3.sv ----
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: inputs are static straps or slow levels from outside
// Notes: output moves only when stages two and three agree

`timescale 1ns/1ns

module lps_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } lps_sync_t;

  lps_sync_t s;
  lps_sync_t next_s;

  initial begin
    if (WIDTH < 1) begin
      $error("lps_sync3 width must be at least one");
    end
  end

  always_comb begin
    next_s = s;
    next_s.s1 = i_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.level[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      // idle high, so shown columns agree with their reset value
      s <= '1;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

endmodule

// ---- src/lps_setup.sv ----
// Purpose: command setup of pointers, areas, mode and attribute decode
// Assumes: host bytes arrive from same-clock logic as one-cycle strobes
// Notes: data bytes are stacked, the command byte then consumes them

`timescale 1ns/1ns

module lps_setup import lps_pkg::*; #(
  parameter logic [6:0] COLS_LOW_LOW = 7'h28,
  parameter logic [6:0] COLS_LOW_HIGH = 7'h28,
  parameter logic [6:0] COLS_HIGH_LOW = 7'h28
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [7:0] i_byte,
  input wire logic i_data_wr,
  input wire logic i_cmd_wr,
  input wire logic i_column_select_a,
  input wire logic i_column_select_b,
  input wire logic i_dual_scan,
  input wire logic i_fetch_go,
  input wire logic [7:0] i_fetch_row,
  input wire logic [6:0] i_fetch_col,
  input wire logic i_cg_go,
  input wire logic [7:0] i_cg_code,
  input wire logic [2:0] i_cg_line,
  input wire logic i_attr_go,
  input wire logic [7:0] i_attr_byte,
  output logic [lps_pkg::LPS_CUR_X_W-1:0] o_cursor_x,
  output logic [lps_pkg::LPS_CUR_Y_W-1:0] o_cursor_y,
  output logic [3:0] o_cursor_row,
  output logic o_cursor_lower,
  output logic [lps_pkg::LPS_OFFSET_W-1:0] o_cg_offset,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_addr_pointer,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_text_base,
  output logic [7:0] o_text_width,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_graphic_base,
  output logic [7:0] o_graphic_width,
  output logic [2:0] o_combine_mode,
  output logic o_ext_cg,
  output logic o_attr_mode,
  output logic o_graphic_suppress,
  output logic [lps_pkg::LPS_COLS_W-1:0] o_visible_columns,
  output logic o_text_contig,
  output logic o_graphic_contig,
  output logic o_fetch_done,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_text_addr,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_graphic_addr,
  output logic o_cg_valid,
  output logic [lps_pkg::LPS_ADDR_W-1:0] o_cg_addr,
  output logic o_cg_from_rom,
  output logic o_attr_valid,
  output logic o_attr_reverse,
  output logic o_attr_inhibit,
  output logic o_attr_bold,
  output logic o_attr_blink
);
  import lps_pkg::*;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] d_old;
    logic [7:0] d_new;
    logic [LPS_CUR_X_W-1:0] cur_x;
    logic [LPS_CUR_Y_W-1:0] cur_y;
    logic [3:0] cur_row;
    logic cur_lower;
    logic [LPS_OFFSET_W-1:0] cg_offset;
    logic [LPS_ADDR_W-1:0] addr_ptr;
    logic [LPS_ADDR_W-1:0] text_base;
    logic [7:0] text_width;
    logic [LPS_ADDR_W-1:0] graphic_base;
    logic [7:0] graphic_width;
    logic [2:0] combine;
    logic ext_cg;
    logic attr_mode;
    logic [LPS_COLS_W-1:0] vis_cols;
    logic text_contig;
    logic graphic_contig;
    lps_fetch_t fstate;
    logic [7:0] f_row;
    logic [6:0] f_col;
    logic fetch_done;
    logic [LPS_ADDR_W-1:0] text_addr;
    logic [LPS_ADDR_W-1:0] graphic_addr;
    logic cg_valid;
    logic [LPS_ADDR_W-1:0] cg_addr;
    logic cg_rom;
    logic attr_valid;
    logic attr_rev;
    logic attr_inh;
    logic attr_bold;
    logic attr_blink;
  } lps_state_t;

  lps_state_t s;
  lps_state_t next_s;
  logic [1:0] col_sel;
  logic dual;
  logic [LPS_ADDR_W-1:0] text_off;
  logic [LPS_ADDR_W-1:0] graphic_off;

  initial begin
    if (COLS_LOW_LOW == 7'h00 || COLS_LOW_HIGH == 7'h00 ||
        COLS_HIGH_LOW == 7'h00) begin
      $error("lps_setup column counts must be nonzero");
    end
  end

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  lps_sync3 #(.WIDTH(3)) u_pins (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_pin({i_dual_scan, i_column_select_b, i_column_select_a}),
    .o_level({dual, col_sel})
  );

  // row start plus column offset inside one plane
  function automatic logic [LPS_ADDR_W-1:0] lps_row_off(
    input logic [7:0] row,
    input logic [7:0] width,
    input logic [6:0] col
  );
    logic [15:0] prod;
    prod = {8'h00, row} * {8'h00, width};
    return prod + {9'h000, col};
  endfunction

  assign text_off = lps_row_off(s.f_row, s.text_width, s.f_col);
  assign graphic_off = lps_row_off(s.f_row, s.graphic_width, s.f_col);

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.fetch_done = 1'b0;
    next_s.cg_valid = 1'b0;
    next_s.attr_valid = 1'b0;
    // last two data bytes are the operands
    if (i_data_wr) begin
      next_s.d_old = s.d_new;
      next_s.d_new = i_byte;
    end
    if (i_cmd_wr) begin
      if (i_byte == LPS_CMD_CURSOR) begin
        next_s.cur_x = s.d_old[LPS_CUR_X_W-1:0];
        next_s.cur_y = s.d_new[LPS_CUR_Y_W-1:0];
      end else if (i_byte == LPS_CMD_OFFSET) begin
        next_s.cg_offset = s.d_old[LPS_OFFSET_W-1:0];
      end else if (i_byte == LPS_CMD_ADDR_PTR) begin
        next_s.addr_ptr = {s.d_new, s.d_old};
      end else if (i_byte == LPS_CMD_TEXT_BASE) begin
        next_s.text_base = {s.d_new, s.d_old};
      end else if (i_byte == LPS_CMD_TEXT_WIDTH) begin
        next_s.text_width = s.d_old;
      end else if (i_byte == LPS_CMD_GRAPHIC_BASE) begin
        next_s.graphic_base = {s.d_new, s.d_old};
      end else if (i_byte == LPS_CMD_GRAPHIC_WIDTH) begin
        next_s.graphic_width = s.d_old;
      end else if (i_byte[7:4] == LPS_CMD_MODE_SET_HI) begin
        next_s.combine = i_byte[2:0];
        next_s.ext_cg = i_byte[LPS_MODE_EXT_BIT];
        next_s.attr_mode = (i_byte[2:0] == LPS_MODE_ATTR);
      end
    end
    // cursor row split by scan mode
    next_s.cur_lower = dual && s.cur_y[LPS_CUR_HALF_BIT];
    next_s.cur_row = s.cur_y[3:0];
    // shown columns from pins
    if (col_sel == 2'b11) begin
      next_s.vis_cols = LPS_COLS_BOTH_HIGH;
    end else if (col_sel == 2'b10) begin
      next_s.vis_cols = COLS_HIGH_LOW;
    end else if (col_sel == 2'b01) begin
      next_s.vis_cols = COLS_LOW_HIGH;
    end else begin
      next_s.vis_cols = COLS_LOW_LOW;
    end
    next_s.text_contig = (s.text_width == {1'b0, s.vis_cols});
    next_s.graphic_contig = (s.graphic_width == {1'b0, s.vis_cols});
    // fetch address sequencer
    case (s.fstate)
      LPS_F_IDLE: begin
        if (i_fetch_go) begin
          next_s.f_row = i_fetch_row;
          next_s.f_col = i_fetch_col;
          next_s.fstate = LPS_F_CALC;
        end
      end
      LPS_F_CALC: begin
        next_s.text_addr = s.text_base + text_off;
        if (s.attr_mode) begin
          next_s.graphic_addr = s.graphic_base + text_off;
        end else begin
          next_s.graphic_addr = s.graphic_base + graphic_off;
        end
        next_s.fetch_done = 1'b1;
        next_s.fstate = LPS_F_IDLE;
      end
      default: begin
        next_s.fstate = LPS_F_IDLE;
      end
    endcase
    // character generator address
    if (i_cg_go) begin
      next_s.cg_addr = {s.cg_offset, i_cg_code, i_cg_line};
      next_s.cg_rom = !s.ext_cg && (i_cg_code <= LPS_ROM_LAST_CODE);
      next_s.cg_valid = 1'b1;
    end
    // attribute decode, upper nibble ignored
    if (i_attr_go) begin
      next_s.attr_valid = 1'b1;
      next_s.attr_blink = i_attr_byte[LPS_ATTR_BLINK_BIT];
      next_s.attr_rev = (i_attr_byte[2:0] == LPS_ATTR_REVERSE);
      next_s.attr_inh = (i_attr_byte[2:0] == LPS_ATTR_INHIBIT);
      next_s.attr_bold = (i_attr_byte[2:0] == LPS_ATTR_BOLD);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
      s.text_base <= LPS_RST_ADDR;
      s.graphic_base <= LPS_RST_ADDR;
      s.addr_ptr <= LPS_RST_ADDR;
      s.text_width <= LPS_RST_BYTE;
      s.graphic_width <= LPS_RST_BYTE;
      s.combine <= LPS_RST_MODE;
      s.vis_cols <= LPS_RST_COLS;
      s.fstate <= LPS_F_IDLE;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign o_cursor_x = s.cur_x;
  assign o_cursor_y = s.cur_y;
  assign o_cursor_row = s.cur_row;
  assign o_cursor_lower = s.cur_lower;
  assign o_cg_offset = s.cg_offset;
  assign o_addr_pointer = s.addr_ptr;
  assign o_text_base = s.text_base;
  assign o_text_width = s.text_width;
  assign o_graphic_base = s.graphic_base;
  assign o_graphic_width = s.graphic_width;
  assign o_combine_mode = s.combine;
  assign o_ext_cg = s.ext_cg;
  assign o_attr_mode = s.attr_mode;
  assign o_graphic_suppress = s.attr_mode;
  assign o_visible_columns = s.vis_cols;
  assign o_text_contig = s.text_contig;
  assign o_graphic_contig = s.graphic_contig;
  assign o_fetch_done = s.fetch_done;
  assign o_text_addr = s.text_addr;
  assign o_graphic_addr = s.graphic_addr;
  assign o_cg_valid = s.cg_valid;
  assign o_cg_addr = s.cg_addr;
  assign o_cg_from_rom = s.cg_rom;
  assign o_attr_valid = s.attr_valid;
  assign o_attr_reverse = s.attr_rev;
  assign o_attr_inhibit = s.attr_inh;
  assign o_attr_bold = s.attr_bold;
  assign o_attr_blink = s.attr_blink;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_cmd_cursor;
    i_ce && i_cmd_wr && i_byte == LPS_CMD_CURSOR;
  endsequence

  sequence s_fetch_start;
    i_ce && i_fetch_go && s.fstate == LPS_F_IDLE;
  endsequence

  property p_cursor_load;
    s_cmd_cursor |=> o_cursor_x == $past(s.d_old[6:0]) &&
      o_cursor_y == $past(s.d_new[4:0]);
  endproperty
  a_cursor_load: assert property (p_cursor_load)
    else $error("cursor not loaded from stacked bytes");

  property p_cursor_hold;
    !(i_ce && i_cmd_wr && i_byte == LPS_CMD_CURSOR) |=>
      $stable(o_cursor_x) && $stable(o_cursor_y);
  endproperty
  a_cursor_hold: assert property (p_cursor_hold)
    else $error("cursor moved without its command");

  property p_lower_half;
    i_ce |=> o_cursor_lower == ($past(dual) && $past(o_cursor_y[4]));
  endproperty
  a_lower_half: assert property (p_lower_half)
    else $error("lower half flag wrong");

  property p_cg_addr;
    i_ce && i_cg_go |=> o_cg_valid &&
      o_cg_addr == {$past(o_cg_offset), $past(i_cg_code), $past(i_cg_line)};
  endproperty
  a_cg_addr: assert property (p_cg_addr)
    else $error("cg address not formed from offset code and line");

  property p_cg_source;
    i_ce && i_cg_go |=> o_cg_from_rom ==
      (!$past(o_ext_cg) && !$past(i_cg_code[7]));
  endproperty
  a_cg_source: assert property (p_cg_source)
    else $error("cg source selection wrong");

  property p_mode_set;
    i_ce && i_cmd_wr && i_byte[7:4] == 4'h8 |=>
      o_combine_mode == $past(i_byte[2:0]) && o_ext_cg == $past(i_byte[3]);
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("mode set not taken");

  property p_mode_hold;
    !(i_ce && i_cmd_wr) |=> $stable(o_combine_mode) && $stable(o_ext_cg);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed without a command");

  property p_fetch_text;
    s_fetch_start ##1 i_ce |=> o_fetch_done && o_text_addr ==
      16'($past(o_text_base) + 16'($past(i_fetch_row, 2)) *
      16'($past(o_text_width)) + 16'($past(i_fetch_col, 2)));
  endproperty
  a_fetch_text: assert property (p_fetch_text)
    else $error("text row address wrong or late");

  property p_attr_decode;
    i_ce && i_attr_go |=> o_attr_valid &&
      o_attr_blink == $past(i_attr_byte[3]) &&
      o_attr_reverse == ($past(i_attr_byte[2:0]) == 3'h5);
  endproperty
  a_attr_decode: assert property (p_attr_decode)
    else $error("attribute decode wrong");

  property p_visible_cols;
    i_ce && col_sel == 2'b11 |=> o_visible_columns == 7'h20;
  endproperty
  a_visible_cols: assert property (p_visible_cols)
    else $error("both pins high must show 32 columns");

endmodule

// ---- testbench/lps_host_model.sv ----
// Purpose: host processor model writing data and command bytes
// Assumes: same clock as the setup block, at most one byte per cycle
// Notes: each idle cycle inverts the byte line, so it toggles while idle

`timescale 1ns/1ns

module lps_host_model (
  input wire logic i_clk,
  output logic [7:0] o_byte,
  output logic o_data_wr,
  output logic o_cmd_wr
);
  initial begin
    o_byte = 8'h00;
    o_data_wr = 1'b0;
    o_cmd_wr = 1'b0;
  end

  task automatic idle();
    @(posedge i_clk);
    o_data_wr <= 1'b0;
    o_cmd_wr <= 1'b0;
    o_byte <= ~o_byte;
  endtask

  // n data bytes, command last, gap idle cycles after each byte
  // both capability flags taken as set; this block reports none
  task automatic send(input int n, input logic [7:0] d1,
      input logic [7:0] d2, input logic [7:0] cmd, input int gap);
    logic [7:0] b;
    for (int k = 0; k <= n; k++) begin
      b = (k == n) ? cmd : ((k == 0) ? d1 : d2);
      @(posedge i_clk);
      o_byte <= b;
      o_data_wr <= (k < n);
      o_cmd_wr <= (k == n);
      for (int g = 0; g < gap; g++) begin
        idle();
      end
    end
    idle();
  endtask
endmodule

// ---- testbench/lps_setup_tb.sv ----
// Purpose: self-checking bench of the pointer, area and mode setup
// Assumes: one clock, host model drives the byte port
// Notes: random values from a bench lfsr seeded with 45

`timescale 1ns/1ns

module lps_setup_tb;
  import lps_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sel_a = 1'b1, sel_b = 1'b1, dual = 1'b1;
  logic fgo = 1'b0, cgo = 1'b0, ago = 1'b0;
  logic ce = 1'b1;
  logic [7:0] frow = 8'h00, ccode = 8'h00, abyte = 8'h00;
  logic [6:0] fcol = 7'h00;
  logic [2:0] cline = 3'h0;
  logic [7:0] hbyte, twidth, gwidth;
  logic hdata, hcmd, cur_low, ext, attr_m, gsup, tcont, gcont, fdone;
  logic cgv, crom, av, arev, ainh, abold, ablink;
  logic [6:0] cur_x, vcols;
  logic [4:0] cur_y, cg_off;
  logic [3:0] cur_row;
  logic [2:0] comb;
  logic [15:0] adp, tbase, gbase, taddr, gaddr, cgaddr;
  logic [15:0] seed = 16'h002d;
  int miscompares = 0;
  int check_count = 0;

  always #2 clk = ~clk;

  lps_host_model i_host (.i_clk(clk), .o_byte(hbyte), .o_data_wr(hdata),
    .o_cmd_wr(hcmd));

  lps_setup #(.COLS_LOW_LOW(7'h14), .COLS_LOW_HIGH(7'h18),
    .COLS_HIGH_LOW(7'h1c)) i_lps_setup (
    .i_clk(clk), .i_reset(reset), .i_ce(ce), .i_byte(hbyte),
    .i_data_wr(hdata), .i_cmd_wr(hcmd), .i_column_select_a(sel_a),
    .i_column_select_b(sel_b), .i_dual_scan(dual), .i_fetch_go(fgo),
    .i_fetch_row(frow), .i_fetch_col(fcol), .i_cg_go(cgo),
    .i_cg_code(ccode), .i_cg_line(cline), .i_attr_go(ago),
    .i_attr_byte(abyte), .o_cursor_x(cur_x), .o_cursor_y(cur_y),
    .o_cursor_row(cur_row), .o_cursor_lower(cur_low), .o_cg_offset(cg_off),
    .o_addr_pointer(adp), .o_text_base(tbase), .o_text_width(twidth),
    .o_graphic_base(gbase), .o_graphic_width(gwidth),
    .o_combine_mode(comb), .o_ext_cg(ext), .o_attr_mode(attr_m),
    .o_graphic_suppress(gsup), .o_visible_columns(vcols),
    .o_text_contig(tcont), .o_graphic_contig(gcont), .o_fetch_done(fdone),
    .o_text_addr(taddr), .o_graphic_addr(gaddr), .o_cg_valid(cgv),
    .o_cg_addr(cgaddr), .o_cg_from_rom(crom), .o_attr_valid(av),
    .o_attr_reverse(arev), .o_attr_inhibit(ainh), .o_attr_bold(abold),
    .o_attr_blink(ablink));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  function automatic logic [3:0] exp_attr(input logic [3:0] n);
    return {n[2:0] == 3'h5, n[2:0] == 3'h3, n[2:0] == 3'h7, n[3]};
  endfunction

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic give_up(input int n);
    if (n >= 16) begin
      miscompares++;
      $display("ERROR %0t wait ran out", $time);
      test_done();
    end
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  logic [7:0] d1, d2, cmd, code;
  logic [15:0] e_adp, e_tb, e_gb, e_t, e_g;
  logic [7:0] e_tw, e_gw;
  logic [4:0] e_off;
  logic [7:0] tbl [6] = '{8'h22, 8'h24, 8'h40, 8'h41, 8'h42, 8'h43};
  int n;

  initial begin
    {e_adp, e_tb, e_gb, e_tw, e_gw, e_off} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk(16'(vcols), 16'h0020, "reset columns");
    for (int v = 0; v < 16; v++) begin
      i_host.send(0, 8'h00, 8'h00, {4'h8, 4'(v)}, v % 2);
      settle();
      chk(16'(comb), 16'(v % 8), "mode combine");
      chk(16'(ext), 16'(v / 8), "mode generator");
      chk(16'({attr_m, gsup}), {14'h0, {2{v % 8 == 4}}}, "attr mode");
    end
    for (int i = 0; i < 12; i++) begin
      cmd = tbl[i % 6];
      d1 = rnd();
      d2 = (cmd == 8'h24 || cmd[1:0] == 2'b00 || cmd == 8'h42) ? rnd() : 8'h00;
      i_host.send(2, d1, d2, cmd, rnd() % 3);
      settle();
      case (cmd)
        8'h22: e_off = d1[4:0];
        8'h24: e_adp = {d2, d1};
        8'h40: e_tb = {d2, d1};
        8'h41: e_tw = d1;
        8'h42: e_gb = {d2, d1};
        default: e_gw = d1;
      endcase
      chk(16'(cg_off), 16'(e_off), "offset");
      chk(adp, e_adp, "address pointer");
      chk(tbase, e_tb, "text base");
      chk(gbase, e_gb, "graphic base");
      chk({twidth, gwidth}, {e_tw, e_gw}, "widths");
      chk(16'(comb), 16'h0007, "mode held");
    end
    for (int i = 0; i < 6; i++) begin
      d1 = (i == 0) ? 8'hcf : rnd();
      d2 = (i == 0) ? 8'hff : rnd();
      i_host.send(2, d1, d2, LPS_CMD_CURSOR, i % 3);
      settle();
      chk(16'({cur_x, cur_y}), 16'({d1[6:0], d2[4:0]}), "cursor");
      chk(16'({cur_row, cur_low}), 16'({d2[3:0], dual & d2[4]}),
        "cursor half");
    end
    i_host.send(1, 8'h5a, 8'h00, 8'hc0, 0);
    i_host.send(0, 8'h00, 8'h00, 8'hc1, 0);
    settle();
    chk(16'({cur_x, cur_y}), 16'({d1[6:0], d2[4:0]}), "cursor kept");
    for (int m = 0; m < 2; m++) begin
      i_host.send(0, 8'h00, 8'h00, (m == 1) ? 8'h84 : 8'h80, 0);
      for (int i = 0; i < 4; i++) begin
        d1 = rnd();
        @(posedge clk);
        fgo <= 1'b1;
        frow <= d1;
        fcol <= 7'(rnd());
        @(posedge clk);
        fgo <= 1'b0;
        n = 0;
        while (fdone !== 1'b1 && n < 16) begin
          settle();
          n++;
        end
        give_up(n);
        e_t = e_tb + 16'(frow) * 16'(e_tw) + 16'(fcol);
        e_g = e_gb + 16'(frow) * 16'((m == 1) ? e_tw : e_gw) + 16'(fcol);
        chk(taddr, e_t, "text row address");
        chk(gaddr, e_g, "graphic row address");
      end
    end
    for (int e = 0; e < 2; e++) begin
      i_host.send(0, 8'h00, 8'h00, {4'h8, 1'(e), 3'h0}, 1);
      for (int i = 0; i < 6; i++) begin
        code = (i == 0) ? 8'h7f : ((i == 1) ? 8'h80 : rnd());
        @(posedge clk);
        cgo <= 1'b1;
        ccode <= code;
        cline <= 3'(i);
        @(posedge clk);
        cgo <= 1'b0;
        #1;
        chk(16'(cgv), 16'h0001, "cg valid");
        chk(cgaddr, {e_off, code, 3'(i)}, "cg address");
        chk(16'(crom), 16'(e == 0 && code <= 8'h7f), "cg rom");
      end
    end
    for (int a = 0; a < 16; a++) begin
      @(posedge clk);
      ago <= 1'b1;
      abyte <= {4'(rnd()), 4'(a)};
      @(posedge clk);
      ago <= 1'b0;
      #1;
      chk(16'({av, arev, ainh, abold, ablink}), 16'({1'b1, exp_attr(4'(a))}),
        "attribute");
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      {sel_b, sel_a} <= 2'(s);
      n = 0;
      while (vcols !== 7'(8'h14 + 4 * s) && n < 16) begin
        settle();
        n++;
      end
      chk(16'(vcols), 16'(8'h14 + 4 * s), "columns");
    end
    i_host.send(2, 8'h20, 8'h00, LPS_CMD_TEXT_WIDTH, 0);
    i_host.send(2, 8'h21, 8'h00, LPS_CMD_GRAPHIC_WIDTH, 0);
    settle();
    settle();
    chk(16'({tcont, gcont}), 16'h0002, "contiguous rows");
    @(posedge clk);
    ce <= 1'b0;
    ago <= 1'b1;
    abyte <= 8'h05;
    @(posedge clk);
    ago <= 1'b0;
    #1;
    chk(16'({av, arev}), 16'h0000, "frozen by clock enable");
    @(posedge clk);
    ce <= 1'b1;
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    settle();
    chk(tbase, 16'h0000, "second reset");
    test_done();
  end
endmodule
